/* pct_defs.vh */
/*
 * constants of the pin continuity check block: timing figures, derived
 * cycle counts, mode state codes, minterm count and data width.
 * assumes a core clock of 250 MHz and includes by bare name.
 */
`ifndef PCT_DEFS_VH
`define PCT_DEFS_VH

`define PCT_CLK_PERIOD_NS    4
`define PCT_ENTRY_DELAY_NS   200
`define PCT_SETTLE_NS        200
// pin sync and state flop use three cycles of the entry budget
`define PCT_SYNC_LAT         3
`define PCT_ENTRY_CYC \
	(`PCT_ENTRY_DELAY_NS / `PCT_CLK_PERIOD_NS - `PCT_SYNC_LAT)
`define PCT_SETTLE_CYC (`PCT_SETTLE_NS / `PCT_CLK_PERIOD_NS)
`define PCT_CNT_W            8

`define PCT_ST_NORMAL        2'h0
`define PCT_ST_ENTERING      2'h1
`define PCT_ST_ACTIVE        2'h2
`define PCT_ST_EXITED        2'h3

`define PCT_MT_COUNT         10
`define PCT_DQ_W             16

`endif

/* pct_sync.v */
/*
 * two flip-flop level synchroniser for pin inputs.
 * assumes an active-low asynchronous reset already local to i_core_clk.
 */
`timescale 1ns/1ns
module pct_sync #(
	parameter WIDTH = 1
) (
	input  wire             i_core_clk,
	input  wire             i_rst_n,
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule // pct_sync

/* pct_minterm.v */
/*
 * combinational minterm network of the pin continuity check.
 * assumes raw test input pins; holds no storage.
 */
`timescale 1ns/1ns
`include "pct_defs.vh"
module pct_minterm (
	input  wire [16:0]              i_addr,
	input  wire [1:0]               i_ba,
	input  wire [1:0]               i_bg,
	input  wire                     i_act_n,
	input  wire                     i_cke,
	input  wire                     i_odt,
	input  wire                     i_par,
	input  wire                     i_alert_n,
	input  wire                     i_ck_t,
	input  wire                     i_ck_c,
	input  wire                     i_reset_n,
	input  wire                     i_ten,
	input  wire                     i_ldm_n,
	input  wire                     i_udm_n,
	input  wire                     i_width_x16,
	input  wire                     i_width_x8,
	output wire [`PCT_MT_COUNT-1:0] o_min_term_x
);
	wire mt7_a;
	wire mt7_b;

	assign o_min_term_x[0] = i_addr[1] ^ i_addr[6] ^ i_par;
	assign o_min_term_x[1] = i_addr[8] ^ i_alert_n ^ i_addr[9];
	assign o_min_term_x[2] = i_addr[2] ^ i_addr[5] ^ i_addr[15];
	assign o_min_term_x[3] = i_addr[0] ^ i_addr[7] ^ i_addr[11];
	assign o_min_term_x[4] = i_ck_c ^ i_odt ^ i_addr[15];
	assign o_min_term_x[5] = i_cke ^ i_addr[16] ^ i_addr[10];
	assign o_min_term_x[6] = i_act_n ^ i_addr[4] ^ i_ba[1];
	assign mt7_a = i_width_x16 ? i_udm_n : i_bg[1];
	assign mt7_b = (i_width_x8 | i_width_x16) & i_ldm_n;
	assign o_min_term_x[7] = mt7_a ^ mt7_b ^ i_ck_t;
	assign o_min_term_x[8] = i_addr[14] ^ i_addr[12] ^ i_ba[0];
	assign o_min_term_x[9] = i_bg[0] ^ i_addr[3] ^ (i_reset_n & i_ten);
endmodule // pct_minterm

/* pct_top.v */
/*
 * pin continuity check logic: mode control on the core clock and a
 * purely combinational minterm and output mapping path.
 * assumes test pins arrive raw from the pads; the pad ring resolves
 * the pin level from the active-low output enables.
 */
// Contract
// - raised enable stops clock use; test mode within 200 ns
// - no refresh of any kind while in test mode
// - rising enable accepted in any state, low power included
// - enable may fall anytime; afterwards full reset initialisation needed
// - outputs stable within 200 ns of pattern, enable high, select low
// - minterm 0 and minterm 1 xor equations
// - minterm 2 and minterm 3 xor equations
// - minterm 6 and minterm 8 xor equations
// - minterm 7 depends on width flags and true clock
// - internal x16 and x8 flags pick inputs and output mapping
// - x16 even data pins carry minterms 0..5, odd pins inverted
// - x16 pins 12,13,14 carry minterms 6,7,8; pin 15 inverts 14
// - x16 lower true strobe carries minterm 9
// - x8 pins carry minterms 0..7; strobes carry minterms 8 and 9
// - x4 pins carry xor of minterm pairs; strobes minterms 8, 9
// - test outputs driven only while select low, else released
// - enable high bypasses memory function; unused in normal mode
// - termination off while test mode is active
`timescale 1ns/1ns
`include "pct_defs.vh"
module pct_top #(
	parameter ENTRY_CYCLES = `PCT_ENTRY_CYC
) (
	input  wire                  i_core_clk,
	input  wire                  i_rst_n,
	input  wire                  i_ten,
	input  wire                  i_cs_n,
	input  wire                  i_width_x16,
	input  wire                  i_width_x8,
	input  wire [16:0]           i_addr,
	input  wire [1:0]            i_ba,
	input  wire [1:0]            i_bg,
	input  wire                  i_act_n,
	input  wire                  i_cke,
	input  wire                  i_odt,
	input  wire                  i_par,
	input  wire                  i_alert_n,
	input  wire                  i_ck_t,
	input  wire                  i_ck_c,
	input  wire                  i_reset_n,
	input  wire                  i_ldm_n,
	input  wire                  i_udm_n,
	input  wire [`PCT_DQ_W-1:0]  i_dq,
	output wire [`PCT_DQ_W-1:0]  o_dq,
	output wire [`PCT_DQ_W-1:0]  o_dq_oe_n,
	output wire                  o_dqsl_t,
	output wire                  o_dqsl_t_oe_n,
	output wire                  o_dqsl_c,
	output wire                  o_dqsl_c_oe_n,
	output wire                  o_dqsu_t,
	output wire                  o_dqsu_t_oe_n,
	output wire                  o_dqsu_c,
	output wire                  o_dqsu_c_oe_n,
	output wire                  o_pin_continuity_check,
	output wire                  o_clk_ignore,
	output wire                  o_refresh_inhibit,
	output wire                  o_odt_off,
	output wire                  o_normal_bypass,
	output wire                  o_init_required
);
	localparam [1:0] ST_NORMAL   = `PCT_ST_NORMAL;
	localparam [1:0] ST_ENTERING = `PCT_ST_ENTERING;
	localparam [1:0] ST_ACTIVE   = `PCT_ST_ACTIVE;
	localparam [1:0] ST_EXITED   = `PCT_ST_EXITED;
	localparam [`PCT_CNT_W-1:0] ENTRY_LAST =
		ENTRY_CYCLES[`PCT_CNT_W-1:0] - 8'h01;

	reg                   rst_meta_reg;
	reg                   rst_sync_reg;
	wire                  rst_core_n;
	wire                  ten_sync;
	reg                   width_x16_reg;
	reg                   width_x8_reg;
	reg                   strap_done_reg;
	reg  [1:0]            state_reg;
	reg  [1:0]            state_next;
	reg  [`PCT_CNT_W-1:0] cnt_reg;
	reg  [`PCT_CNT_W-1:0] cnt_next;
	reg                   clk_ignore_reg;
	reg                   clk_ignore_next;
	reg                   ct_active_reg;
	reg                   ct_active_next;
	reg                   init_req_reg;
	reg                   init_req_next;
	wire [`PCT_MT_COUNT-1:0] min_term_x;
	reg  [`PCT_DQ_W-1:0]  dq_map;
	reg  [`PCT_DQ_W-1:0]  dq_used;
	reg                   dqsl_t_map;
	reg                   dqsl_c_map;
	reg                   dqsu_t_map;
	reg                   dqsu_c_map;
	reg                   dqsu_used;
	wire                  drive;

	// minterm pair xor for narrow parts
	function pair_xor;
		input [`PCT_MT_COUNT-1:0] mt;
		input integer             n;
		begin
			pair_xor = mt[2*n] ^ mt[2*n+1];
		end
	endfunction

	// reset release through two flip-flops
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_core_n = rst_sync_reg;

	pct_sync #(
		.WIDTH (1)
	) u_ten_sync (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_core_n),
		.i_async    (i_ten),
		.o_sync     (ten_sync)
	);

	// width straps caught once after reset release
	always @(posedge i_core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			width_x16_reg  <= 1'b0;
			width_x8_reg   <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			width_x16_reg  <= i_width_x16;
			width_x8_reg   <= i_width_x8 & ~i_width_x16;
			strap_done_reg <= 1'b1;
		end
	end

	// mode control
	always @* begin
		state_next      = state_reg;
		cnt_next        = cnt_reg;
		clk_ignore_next = clk_ignore_reg;
		ct_active_next  = ct_active_reg;
		init_req_next   = init_req_reg;
		case (state_reg)
			ST_NORMAL, ST_EXITED: begin
				if (ten_sync) begin
					state_next      = ST_ENTERING;
					cnt_next        = 8'h00;
					clk_ignore_next = 1'b1;
				end
			end
			ST_ENTERING: begin
				if (!ten_sync) begin
					state_next      = ST_EXITED;
					clk_ignore_next = 1'b0;
					init_req_next   = 1'b1;
				end else if (cnt_reg >= ENTRY_LAST) begin
					state_next     = ST_ACTIVE;
					ct_active_next = 1'b1;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_ACTIVE: begin
				if (!ten_sync) begin
					state_next      = ST_EXITED;
					clk_ignore_next = 1'b0;
					ct_active_next  = 1'b0;
					init_req_next   = 1'b1;
				end
			end
			default: begin
				state_next      = ST_NORMAL;
				clk_ignore_next = 1'b0;
				ct_active_next  = 1'b0;
			end
		endcase
	end

	// state register
	always @(posedge i_core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state_reg      <= ST_NORMAL;
			cnt_reg        <= 8'h00;
			clk_ignore_reg <= 1'b0;
			ct_active_reg  <= 1'b0;
			init_req_reg   <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			clk_ignore_reg <= clk_ignore_next;
			ct_active_reg  <= ct_active_next;
			init_req_reg   <= init_req_next;
		end
	end

	// mode outputs, one flop for all clock-side effects
	assign o_clk_ignore           = clk_ignore_reg;
	assign o_refresh_inhibit      = clk_ignore_reg;
	assign o_odt_off              = clk_ignore_reg;
	assign o_normal_bypass        = clk_ignore_reg;
	assign o_pin_continuity_check = ct_active_reg;
	assign o_init_required        = init_req_reg;

	// combinational test path, settles well inside 200 ns
	pct_minterm u_minterm (
		.i_addr       (i_addr),
		.i_ba         (i_ba),
		.i_bg         (i_bg),
		.i_act_n      (i_act_n),
		.i_cke        (i_cke),
		.i_odt        (i_odt),
		.i_par        (i_par),
		.i_alert_n    (i_alert_n),
		.i_ck_t       (i_ck_t),
		.i_ck_c       (i_ck_c),
		.i_reset_n    (i_reset_n),
		.i_ten        (i_ten),
		.i_ldm_n      (i_ldm_n),
		.i_udm_n      (i_udm_n),
		.i_width_x16  (width_x16_reg),
		.i_width_x8   (width_x8_reg),
		.o_min_term_x (min_term_x)
	);

	// output mapping per width
	always @* begin
		dq_map     = 16'h0000;
		dq_used    = 16'h0000;
		dqsl_t_map = 1'b0;
		dqsl_c_map = 1'b0;
		dqsu_t_map = 1'b0;
		dqsu_c_map = 1'b0;
		dqsu_used  = 1'b0;
		if (width_x16_reg) begin
			dq_map[0]  = min_term_x[0];
			dq_map[1]  = ~min_term_x[0];
			dq_map[2]  = min_term_x[1];
			dq_map[3]  = ~min_term_x[1];
			dq_map[4]  = min_term_x[2];
			dq_map[5]  = ~min_term_x[2];
			dq_map[6]  = min_term_x[3];
			dq_map[7]  = ~min_term_x[3];
			dq_map[8]  = min_term_x[4];
			dq_map[9]  = ~min_term_x[4];
			dq_map[10] = min_term_x[5];
			dq_map[11] = ~min_term_x[5];
			dq_map[12] = min_term_x[6];
			dq_map[13] = min_term_x[7];
			dq_map[14] = min_term_x[8];
			dq_map[15] = ~min_term_x[8];
			dq_used    = 16'hFFFF;
			dqsl_t_map = min_term_x[9];
			dqsl_c_map = ~min_term_x[6];
			dqsu_t_map = ~min_term_x[9];
			dqsu_c_map = ~min_term_x[7];
			dqsu_used  = 1'b1;
		end else if (width_x8_reg) begin
			dq_map[7:0]  = min_term_x[7:0];
			dq_used      = 16'h00FF;
			dqsl_t_map   = min_term_x[8];
			dqsl_c_map   = min_term_x[9];
		end else begin
			dq_map[0]  = pair_xor(min_term_x, 0);
			dq_map[1]  = pair_xor(min_term_x, 1);
			dq_map[2]  = pair_xor(min_term_x, 2);
			dq_map[3]  = pair_xor(min_term_x, 3);
			dq_used    = 16'h000F;
			dqsl_t_map = min_term_x[8];
			dqsl_c_map = min_term_x[9];
		end
	end

	// drive only in test mode with select low
	assign drive = ct_active_reg & ten_sync & ~i_cs_n;

	// pin outputs and their active-low enables
	assign o_dq          = dq_map;
	assign o_dq_oe_n     = ~(dq_used & {`PCT_DQ_W{drive}});
	assign o_dqsl_t      = dqsl_t_map;
	assign o_dqsl_t_oe_n = ~drive;
	assign o_dqsl_c      = dqsl_c_map;
	assign o_dqsl_c_oe_n = ~drive;
	assign o_dqsu_t      = dqsu_t_map;
	assign o_dqsu_t_oe_n = ~(drive & dqsu_used);
	assign o_dqsu_c      = dqsu_c_map;
	assign o_dqsu_c_oe_n = ~(drive & dqsu_used);
endmodule // pct_top

/* pct_sva.sv */
/*
 * checker of pct_top mode outputs and test output path.
 * assumes width straps stay steady while reset is released.
 */
`timescale 1ns/1ns
module pct_sva #(
	parameter ENTRY_CYCLES = 47
) (
	input wire        i_core_clk,
	input wire        i_rst_n,
	input wire        i_ten,
	input wire        i_cs_n,
	input wire        i_width_x16,
	input wire [16:0] i_addr,
	input wire [1:0]  i_ba,
	input wire        i_par,
	input wire [15:0] o_dq,
	input wire [15:0] o_dq_oe_n,
	input wire        o_dqsl_t,
	input wire        o_dqsl_t_oe_n,
	input wire        o_dqsu_t,
	input wire        o_dqsu_t_oe_n,
	input wire        o_pin_continuity_check,
	input wire        o_clk_ignore,
	input wire        o_refresh_inhibit,
	input wire        o_odt_off,
	input wire        o_normal_bypass,
	input wire        o_init_required
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	reg [7:0] wait_reg;
	// cycles since clock use stopped
	always @(posedge i_core_clk or negedge i_rst_n)
		if (!i_rst_n)
			wait_reg <= 8'h00;
		else
			wait_reg <= o_clk_ignore ? wait_reg + 8'h01 : 8'h00;
	wire mode = o_pin_continuity_check;
	sequence s_up; $rose(i_ten) ##1 i_ten; endsequence
	sequence s_down; $fell(i_ten) && o_clk_ignore; endsequence
	property p_entry; s_up |-> ##[0:3] o_clk_ignore; endproperty
	property p_delay; $rose(mode) |-> wait_reg == ENTRY_CYCLES; endproperty
	property p_bound; o_clk_ignore && wait_reg > ENTRY_CYCLES |-> mode;
	endproperty
	property p_refresh; o_refresh_inhibit == o_clk_ignore; endproperty
	property p_odt; o_odt_off == o_clk_ignore; endproperty
	property p_bypass; o_normal_bypass == o_clk_ignore; endproperty
	property p_exit;
		s_down |-> ##[1:3] (!o_clk_ignore && o_init_required);
	endproperty
	property p_keep; o_init_required |=> o_init_required; endproperty
	property p_release;
		i_cs_n |-> &o_dq_oe_n && o_dqsl_t_oe_n && o_dqsu_t_oe_n;
	endproperty
	property p_mt0; mode && i_width_x16 |->
		o_dq[0] == ^{i_addr[1], i_addr[6], i_par} && o_dq[1] != o_dq[0];
	endproperty
	property p_mt8; mode && !i_width_x16 |->
		o_dqsl_t == ^{i_addr[14], i_addr[12], i_ba[0]};
	endproperty
	property p_ustb; mode && i_width_x16 |-> o_dqsu_t != o_dqsl_t;
	endproperty
	a_entry: assert property (p_entry) else $error("late entry");
	a_delay: assert property (p_delay) else $error("entry count");
	a_bound: assert property (p_bound) else $error("entry overdue");
	a_refresh: assert property (p_refresh) else $error("refresh");
	a_odt: assert property (p_odt) else $error("termination");
	a_bypass: assert property (p_bypass) else $error("bypass");
	a_exit: assert property (p_exit) else $error("exit");
	a_keep: assert property (p_keep) else $error("init flag");
	a_release: assert property (p_release) else $error("driven");
	a_mt0: assert property (p_mt0) else $error("minterm 0");
	a_mt8: assert property (p_mt8) else $error("minterm 8");
	a_ustb: assert property (p_ustb) else $error("upper strobe");
endmodule // pct_sva
bind pct_top pct_sva #(.ENTRY_CYCLES(ENTRY_CYCLES)) u_sva (.i_core_clk,
	.i_rst_n, .i_ten, .i_cs_n, .i_width_x16, .i_addr, .i_ba, .i_par, .o_dq,
	.o_dq_oe_n, .o_dqsl_t, .o_dqsl_t_oe_n, .o_dqsu_t, .o_dqsu_t_oe_n,
	.o_pin_continuity_check, .o_clk_ignore, .o_refresh_inhibit, .o_odt_off,
	.o_normal_bypass, .o_init_required);

/* pct_agent.sv */
/*
 * test agent model: drives the test input pins and resolves data pads.
 * assumes patterns are handed over on the core clock.
 */
`timescale 1ns/1ns
module pct_agent (
	input  wire        i_clk,
	input  wire [30:0] i_pat,
	input  wire [15:0] i_dq,
	input  wire [15:0] i_dq_oe_n,
	output reg  [30:0] o_pins,
	output wire [15:0] o_pad
);
	reg [15:0] last_reg;
	initial o_pins = 31'h0;
	initial last_reg = 16'h0;
	// pattern applied just after the edge, held until the next one
	always @(posedge i_clk) o_pins <= #1 i_pat;
	// a released pad keeps toggling away from its last level
	always @(posedge i_clk) last_reg <= o_pad;
	assign o_pad = (~i_dq_oe_n & i_dq) | (i_dq_oe_n & ~last_reg);
endmodule // pct_agent

/* testbench.sv */
/*
 * self-checking bench of pct_top in x16, x8 and x4 strapping.
 * assumes the agent model drives all test input pins except i_ten and i_cs_n, which the bench drives.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	localparam E = 2;
	reg         i_core_clk = 1'b0;
	reg         i_rst_n    = 1'b0;
	reg         i_ten      = 1'b0;
	reg         i_cs_n     = 1'b1;
	reg         w16        = 1'b1;
	reg         w8         = 1'b0;
	reg  [30:0] pat        = 31'h0;
	wire [30:0] p;
	wire [15:0] dq, oe, pad;
	wire [3:0]  soe;
	wire        lt, lc, ut, uc, pcc, ign, rfi, odo, byp, ini;
	integer     err_count = 0;
	integer     tests_run = 0;
	integer     w;
	reg  [9:0]  mt;
	reg  [15:0] edq, eoe;
	reg  [3:0]  es, esoe;
	always #2 i_core_clk = ~i_core_clk;
	pct_top #(.ENTRY_CYCLES(E)) dut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ten(i_ten),
		.i_cs_n(i_cs_n), .i_width_x16(w16), .i_width_x8(w8),
		.i_addr(p[16:0]), .i_ba(p[18:17]), .i_bg(p[20:19]),
		.i_act_n(p[21]), .i_cke(p[22]), .i_odt(p[23]), .i_par(p[24]),
		.i_alert_n(p[25]), .i_ck_t(p[26]), .i_ck_c(p[27]),
		.i_reset_n(p[28]), .i_ldm_n(p[29]), .i_udm_n(p[30]), .i_dq(pad),
		.o_dq(dq), .o_dq_oe_n(oe), .o_dqsl_t(lt), .o_dqsl_t_oe_n(soe[3]),
		.o_dqsl_c(lc), .o_dqsl_c_oe_n(soe[2]), .o_dqsu_t(ut),
		.o_dqsu_t_oe_n(soe[1]), .o_dqsu_c(uc), .o_dqsu_c_oe_n(soe[0]),
		.o_pin_continuity_check(pcc), .o_clk_ignore(ign),
		.o_refresh_inhibit(rfi), .o_odt_off(odo), .o_normal_bypass(byp),
		.o_init_required(ini));
	pct_agent agent (.i_clk(i_core_clk), .i_pat(pat), .i_dq(dq),
		.i_dq_oe_n(oe), .o_pins(p), .o_pad(pad));
	task step;
		begin
			@(posedge i_core_clk);
			#1;
		end
	endtask
	task conclude;
		begin
			$display("errors %0d checks %0d", err_count, tests_run);
			if (err_count == 0 && tests_run > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task do_reset(input x16, input x8);
		begin
			i_rst_n = 1'b0;
			w16 = x16;
			w8 = x8;
			repeat (12) step;
			i_rst_n = 1'b1;
			repeat (4) step;
		end
	endtask
	task expect_out;
		integer k;
		begin
			mt[0] = p[1] ^ p[6] ^ p[24];
			mt[1] = p[8] ^ p[25] ^ p[9];
			mt[2] = p[2] ^ p[5] ^ p[15];
			mt[3] = p[0] ^ p[7] ^ p[11];
			mt[4] = p[27] ^ p[23] ^ p[15];
			mt[5] = p[22] ^ p[16] ^ p[10];
			mt[6] = p[21] ^ p[4] ^ p[18];
			mt[7] = (w16 ? p[30] : p[20]) ^ ((w8 | w16) & p[29]) ^ p[26];
			mt[8] = p[14] ^ p[12] ^ p[17];
			mt[9] = p[19] ^ p[3] ^ (p[28] & i_ten);
			edq = 16'h0000;
			esoe = 4'h3;
			es = {mt[8], mt[9], 2'h0};
			if (w16) begin
				for (k = 0; k < 6; k++)
					edq[2*k +: 2] = {~mt[k], mt[k]};
				edq[15:12] = {~mt[8], mt[8:6]};
				eoe = 16'h0000;
				esoe = 4'h0;
				es = {mt[9], ~mt[6], ~mt[9], ~mt[7]};
			end else if (w8) begin
				edq[7:0] = mt[7:0];
				eoe = 16'hFF00;
			end else begin
				for (k = 0; k < 4; k++)
					edq[k] = mt[2*k] ^ mt[2*k+1];
				eoe = 16'hFFF0;
			end
		end
	endtask
	task t_entry;
		begin
			i_ten = 1'b1;
			repeat (3) step;
			`CHK({ign, rfi, odo, byp}, 4'hF)
			repeat (E - 1) step;
			`CHK(pcc, 1'b0)
			step;
			`CHK(pcc, 1'b1)
		end
	endtask
	task t_map;
		integer k;
		begin
			i_cs_n = 1'b0;
			for (k = -1; k < 32; k++) begin
				pat = (k < 0) ? 31'h0 : (k > 30) ? 31'h7FFFFFFF : 31'h1 << k;
				repeat (51) step;
				expect_out;
				`CHK(oe, eoe)
				`CHK(dq & ~eoe, edq)
				`CHK(soe, esoe)
				`CHK({lt, lc, ut, uc} & ~esoe, es & ~esoe)
			end
		end
	endtask
	task t_release;
		begin
			i_cs_n = 1'b1;
			step;
			`CHK({oe, soe}, 20'hFFFFF)
			i_cs_n = 1'b0;
			step;
			`CHK(soe[3], 1'b0)
		end
	endtask
	task t_exit;
		begin
			i_ten = 1'b0;
			repeat (3) step;
			`CHK({ign, rfi, odo, byp, pcc, ini}, 6'h01)
			`CHK({oe, soe}, 20'hFFFFF)
		end
	endtask
	initial begin
		for (w = 0; w < 3; w++) begin
			do_reset(w == 0, w == 1);
			`CHK({ign, pcc, ini, oe[0]}, 4'h1)
			t_entry;
			t_map;
			t_release;
			t_exit;
			t_entry;
			t_exit;
		end
		conclude;
	end
	initial begin
		#60000;
		err_count++;
		conclude;
	end
endmodule // testbench
